//--- rtl/etws_pkg.sv
// Contract
// - Ignore bus until power-on, then Standby
// - Master waits power-up time before commanding
// - Supply dip: hold off, repeat power-up
// - Sample on SCL rise, drive on fall
// - MSB first, eight bits, ninth acknowledge
// - Master clocks bytes without gaps; this master idles in ETWS_IDLE, SCL low, between bytes
// - SDA changes only while SCL low
// - SDA fall, SCL high: Start wakes device
// - Watch lines, respond only after Start
// - SDA rise, SCL high: Stop ends transfer
// - Repeated Start begins a new command
// - Transmitter releases; receiver holds ninth low
// - Master NACK ends read; device releases
// - Receiver releases SDA after ninth clock
// - Standby after power-up, Stop, write done
// - No limit on bytes per transfer
// - Idle only when both lines high
// - Recovery: up to nine clocks, then Start
// - Still stuck: cycle power
// - SDA driven low or released only
package etws_pkg;
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned PUP_TIME_US    = 100;
    localparam int unsigned PUP_CYCLES     =
        (PUP_TIME_US * (CLK_HZ / 1_000_000));
    localparam int unsigned POFF_TIME_MS   = 500;
    localparam int unsigned DIV_HALF       = 4;
    localparam int unsigned RECOVER_CLOCKS = 9;
    localparam logic [3:0]  BIT_LAST       = 4'h7;
    localparam logic [3:0]  BIT_ACK        = 4'h8;
endpackage

//--- rtl/etws_bus_if.sv
`timescale 1ns/10ps
interface etws_bus_if;
    logic scl;
    logic m_sda_out;
    logic m_sda_oe;
    logic s_sda_out;
    logic s_sda_oe;
    logic sda;
    assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));
    modport dev (input scl, input sda, output s_sda_out, output s_sda_oe);
    modport mst (output scl, input sda, output m_sda_out, output m_sda_oe);
endinterface

//--- rtl/etws_slave.sv
`timescale 1ns/10ps
module etws_slave
    import etws_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // Power-on level
    input  wire logic       por_done_in,
    // Bus
    etws_bus_if.dev         bus,
    // Memory side
    output logic [7:0]      rx_byte_out,
    output logic            rx_strobe_out,
    input  wire logic       ack_req_in,
    input  wire logic [7:0] tx_byte_in,
    input  wire logic       tx_mode_in,
    input  wire logic       wr_busy_in,
    output logic            start_out,
    output logic            stop_out,
    output logic            active_out
);
    import etws_pkg::*;

    typedef enum logic [2:0]
    {
        ETWS_OFF  = 3'b001,
        ETWS_STBY = 3'b010,
        ETWS_XFER = 3'b100
    } etws_state_e;

    // --------------------------------
    // Synchronisers
    // --------------------------------
    logic [1:0] scl_s_reg, sda_s_reg, por_s_reg;
    logic       scl_d_reg, sda_d_reg;
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            scl_s_reg <= 2'h3;
            sda_s_reg <= 2'h3;
            por_s_reg <= 2'h0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_s_reg <= {scl_s_reg[0], bus.scl};
            sda_s_reg <= {sda_s_reg[0], bus.sda};
            por_s_reg <= {por_s_reg[0], por_done_in};
            scl_d_reg <= scl_s_reg[1];
            sda_d_reg <= sda_s_reg[1];
        end
    end

    // --------------------------------
    // Edge and condition detect
    // --------------------------------
    wire scl_w   = scl_s_reg[1];
    wire sda_w   = sda_s_reg[1];
    wire scl_ris = scl_w & ~scl_d_reg;
    wire scl_fal = ~scl_w & scl_d_reg;
    // Start and Stop need SCL high on two samples in a row
    wire start_w = scl_w & scl_d_reg & sda_d_reg & ~sda_w;
    wire stop_w  = scl_w & scl_d_reg & ~sda_d_reg & sda_w;

    // --------------------------------
    // Protocol state
    // --------------------------------
    etws_state_e state_reg;
    logic [3:0]  bit_reg;
    logic [7:0]  shift_reg;
    logic        drive_low_reg;
    logic        tx_reg;
    logic        nack_reg;
    logic        ack_bit_reg;
    logic        rise_seen_reg;

    // --------------------------------
    // Bit decode
    // --------------------------------
    wire in_xfer   = (state_reg == ETWS_XFER);
    wire at_ack    = (bit_reg == BIT_ACK);
    wire last_bit  = (bit_reg == BIT_LAST);
    // Read NACK halts the engine until the next Start; only a Start or reset clears nack_reg
    wire bit_live  = in_xfer & ~nack_reg;
    wire bit_rise  = bit_live & scl_ris;
    // The SCL fall that closes a Start is no data bit
    wire bit_fall  = bit_live & rise_seen_reg & scl_fal;
    // Transmit bits leave from the top of the shifter
    wire tx_low    = tx_reg & ~shift_reg[7];
    wire ack_low   = ~tx_reg & ack_req_in;
    wire load_low  = tx_mode_in & ~tx_byte_in[7];
    wire nack_seen = tx_reg & ack_bit_reg;

    // --------------------------------
    // Bit engine
    // --------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg     <= ETWS_OFF;
            bit_reg       <= 4'h0;
            shift_reg     <= 8'h00;
            drive_low_reg <= 1'b0;
            tx_reg        <= 1'b0;
            nack_reg      <= 1'b0;
            ack_bit_reg   <= 1'b0;
            rise_seen_reg <= 1'b0;
            rx_byte_out   <= 8'h00;
            rx_strobe_out <= 1'b0;
            start_out     <= 1'b0;
            stop_out      <= 1'b0;
        end
        else
        begin
            rx_strobe_out <= 1'b0;
            start_out     <= 1'b0;
            stop_out      <= 1'b0;
            // Supply below threshold: held in reset, bus ignored
            if (!por_s_reg[1])
            begin
                state_reg     <= ETWS_OFF;
                drive_low_reg <= 1'b0;
                bit_reg       <= 4'h0;
            end
            else if (state_reg == ETWS_OFF)
                state_reg <= ETWS_STBY;
            // Write cycle running: the bus is not answered
            else if (wr_busy_in)
            begin
                state_reg     <= ETWS_STBY;
                drive_low_reg <= 1'b0;
            end
            else if (start_w)
            begin
                state_reg     <= ETWS_XFER;
                bit_reg       <= 4'h0;
                drive_low_reg <= 1'b0;
                tx_reg        <= 1'b0;
                nack_reg      <= 1'b0;
                rise_seen_reg <= 1'b0;
                start_out     <= 1'b1;
            end
            else if (stop_w)
            begin
                state_reg     <= ETWS_STBY;
                bit_reg       <= 4'h0;
                drive_low_reg <= 1'b0;
                stop_out      <= in_xfer;
            end
            else
            begin
                if (bit_rise)
                begin
                    rise_seen_reg <= 1'b1;
                    if (at_ack)
                        ack_bit_reg <= sda_w;
                    else
                        shift_reg <= {shift_reg[6:0], sda_w};
                end
                if (bit_fall)
                begin
                    if (at_ack)
                    begin
                        bit_reg <= 4'h0;
                        if (nack_seen)
                        begin
                            nack_reg      <= 1'b1;
                            drive_low_reg <= 1'b0;
                        end
                        else
                        begin
                            tx_reg        <= tx_mode_in;
                            drive_low_reg <= load_low;
                            shift_reg     <= tx_byte_in;
                        end
                    end
                    else if (last_bit)
                    begin
                        bit_reg       <= BIT_ACK;
                        drive_low_reg <= ack_low;
                        if (!tx_reg)
                        begin
                            rx_byte_out   <= shift_reg;
                            rx_strobe_out <= 1'b1;
                        end
                    end
                    else
                    begin
                        bit_reg       <= bit_reg + 4'h1;
                        drive_low_reg <= tx_low;
                    end
                end
            end
        end
    end

    // --------------------------------
    // Bus and status outputs
    // --------------------------------
    // Open drain: only ever pulls low or lets go
    assign bus.s_sda_out = 1'b0;
    assign bus.s_sda_oe  = drive_low_reg;
    assign active_out    = in_xfer;
endmodule

//--- rtl/etws_master.sv
`timescale 1ns/10ps
module etws_master
    import etws_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // Command
    input  wire logic       start_in,
    input  wire logic       stop_in,
    input  wire logic       byte_in,
    input  wire logic       recover_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       read_in,
    input  wire logic       nack_in,
    output logic            ready_out,
    output logic [7:0]      rdata_out,
    output logic            ack_out,
    output logic            done_out,
    // Bus
    etws_bus_if.mst         bus
);
    import etws_pkg::*;

    typedef enum logic [4:0]
    {
        ETWS_WAIT = 5'b00001,
        ETWS_IDLE = 5'b00010,
        ETWS_COND = 5'b00100,
        ETWS_BITS = 5'b01000,
        ETWS_REC  = 5'b10000
    } etws_mstate_e;

    etws_mstate_e state_reg;
    logic [15:0]  pup_reg;
    logic [2:0]   div_reg;
    logic [1:0]   ph_reg;
    logic [3:0]   cnt_reg;
    logic [8:0]   sh_reg;
    logic [8:0]   rd_reg;
    logic         scl_reg, sda_reg, stop_reg, rd_mode_reg;
    logic [1:0]   sda_s_reg;

    wire tick   = (div_reg == 3'(DIV_HALF - 1));
    wire sda_w  = sda_s_reg[1];
    wire pup_ok = (pup_reg == 16'(PUP_CYCLES));

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= ETWS_WAIT;
            pup_reg <= 16'h0000;
            div_reg <= 3'h0;
            ph_reg <= 2'h0;
            cnt_reg <= 4'h0;
            sh_reg <= 9'h1FF;
            rd_reg <= 9'h000;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            stop_reg <= 1'b0;
            rd_mode_reg <= 1'b0;
            sda_s_reg <= 2'h3;
            rdata_out <= 8'h00;
            ack_out <= 1'b0;
            done_out <= 1'b0;
        end
        else
        begin
            sda_s_reg <= {sda_s_reg[0], bus.sda};
            div_reg <= tick ? 3'h0 : div_reg + 3'h1;
            done_out <= 1'b0;
            unique case (state_reg)
                ETWS_WAIT:
                    if (pup_ok)
                        state_reg <= ETWS_IDLE;
                    else
                        pup_reg <= pup_reg + 16'h0001;
                ETWS_IDLE:
                    if (start_in || stop_in)
                    begin
                        stop_reg <= stop_in;
                        ph_reg <= 2'h0;
                        state_reg <= ETWS_COND;
                    end
                    else if (byte_in)
                    begin
                        // Read: release data, drive ack bit
                        sh_reg <= read_in ? {8'hFF, nack_in}
                                          : {wdata_in, 1'b1};
                        rd_mode_reg <= read_in;
                        cnt_reg <= 4'h0;
                        ph_reg <= 2'h0;
                        state_reg <= ETWS_BITS;
                    end
                    else if (recover_in)
                    begin
                        cnt_reg <= 4'h0;
                        ph_reg <= 2'h0;
                        state_reg <= ETWS_REC;
                    end
                ETWS_COND:
                    if (tick)
                    begin
                        ph_reg <= ph_reg + 2'h1;
                        unique case (ph_reg)
                            2'h0: sda_reg <= stop_reg ? 1'b0 : 1'b1;
                            2'h1: scl_reg <= 1'b1;
                            2'h2: sda_reg <= stop_reg;
                            default:
                            begin
                                if (!stop_reg)
                                    scl_reg <= 1'b0;
                                done_out <= 1'b1;
                                state_reg <= ETWS_IDLE;
                            end
                        endcase
                    end
                ETWS_BITS:
                    if (tick)
                    begin
                        ph_reg <= ph_reg + 2'h1;
                        unique case (ph_reg)
                            2'h0: sda_reg <= sh_reg[8];
                            2'h1: scl_reg <= 1'b1;
                            2'h2: rd_reg <= {rd_reg[7:0], sda_w};
                            default:
                            begin
                                scl_reg <= 1'b0;
                                sh_reg <= {sh_reg[7:0], 1'b1};
                                cnt_reg <= cnt_reg + 4'h1;
                                if (cnt_reg == BIT_ACK)
                                begin
                                    sda_reg <= 1'b1;
                                    ack_out <= ~rd_reg[0];
                                    rdata_out <= rd_mode_reg
                                        ? rd_reg[8:1] : rdata_out;
                                    done_out <= 1'b1;
                                    state_reg <= ETWS_IDLE;
                                end
                            end
                        endcase
                    end
                ETWS_REC:
                    if (tick)
                    begin
                        ph_reg <= ph_reg + 2'h1;
                        unique case (ph_reg)
                            2'h0: sda_reg <= 1'b1;
                            2'h1: scl_reg <= 1'b1;
                            2'h2:
                                if (sda_w ||
                                    cnt_reg == 4'(RECOVER_CLOCKS - 1))
                                begin
                                    ack_out <= sda_w;
                                    done_out <= 1'b1;
                                    state_reg <= ETWS_IDLE;
                                end
                            default:
                            begin
                                scl_reg <= 1'b0;
                                cnt_reg <= cnt_reg + 4'h1;
                            end
                        endcase
                    end
                default: state_reg <= ETWS_IDLE;
            endcase
        end
    end

    // Byte read in the ack slot ends in rd_reg with the ack bit last
    assign ready_out     = (state_reg == ETWS_IDLE);
    assign bus.scl       = scl_reg;
    assign bus.m_sda_out = 1'b0;
    assign bus.m_sda_oe  = ~sda_reg;
endmodule

//--- tb/etws_sva.sv
`timescale 1ns/10ps
module etws_sva
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Bus lines
    input wire logic scl,
    input wire logic m_sda_out,
    input wire logic m_sda_oe,
    input wire logic s_sda_out,
    input wire logic s_sda_oe,
    input wire logic sda
);
    logic scl_d;
    logic sda_d;
    logic xfer_reg;
    wire  edge_w  = scl & scl_d & (sda_d != sda);
    wire  stop_w  = edge_w & sda;
    wire  start_w = edge_w & ~sda;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    // Transfer flag: set by a Start, cleared by a Stop
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            {scl_d, sda_d, xfer_reg} <= 3'h6;
        else
        begin
            {scl_d, sda_d} <= {scl, sda};
            if (edge_w)
                xfer_reg <= sda_d;
        end
    end

    // ----------------------------------------
    // Wire properties
    // ----------------------------------------
    property p_scl_high;
        $rose(scl) |-> scl [*8];
    endproperty
    a_scl_high: assert property (p_scl_high)
        else $error("SCL high phase cut short");
    property p_scl_low;
        $fell(scl) |-> !scl [*4];
    endproperty
    a_scl_low: assert property (p_scl_low)
        else $error("SCL low phase cut short");
    property p_sl_low_only;
        s_sda_oe |-> !s_sda_out;
    endproperty
    a_sl_low_only: assert property (p_sl_low_only)
        else $error("Slave drives SDA high");
    property p_ms_low_only;
        m_sda_oe |-> !m_sda_out;
    endproperty
    a_ms_low_only: assert property (p_ms_low_only)
        else $error("Master drives SDA high");
    property p_sl_hold;
        $rose(scl) && s_sda_oe |-> (s_sda_oe && !sda) [*8];
    endproperty
    a_sl_hold: assert property (p_sl_hold)
        else $error("Slave let go of SDA while SCL high");
    property p_sl_change;
        $changed(s_sda_oe) |-> !scl;
    endproperty
    a_sl_change: assert property (p_sl_change)
        else $error("Slave changed SDA while SCL high");
    property p_sl_after_start;
        s_sda_oe |-> xfer_reg;
    endproperty
    a_sl_after_start: assert property (p_sl_after_start)
        else $error("Slave drives SDA outside a transfer");
    property p_idle;
        stop_w |-> (scl && sda) [*2];
    endproperty
    a_idle: assert property (p_idle)
        else $error("Bus not idle after Stop");

    c_start: cover property (start_w);
    c_stop: cover property (stop_w);
    c_ack: cover property ($rose(scl) && s_sda_oe);
endmodule

//--- tb/eeprom_two_wire_slave_frontend_bench.sv
`timescale 1ns/10ps
module eeprom_two_wire_slave_frontend_bench;
    import etws_pkg::*;
    `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
        bad_count++; $display("Error t=%0t got %h exp %h", \
        $time, a, b); end end
    logic       clock_in, rst_n_in, por_done_in, ack_req_in;
    logic       tx_mode_in, wr_busy_in, start_in, stop_in, byte_in;
    logic       recover_in, read_in, nack_in;
    logic [7:0] tx_byte_in, wdata_in, rx_byte_out, rdata_out, rx_last;
    logic       rx_strobe_out, start_out, stop_out, active_out;
    logic       ready_out, ack_out, done_out;
    int         bad_count, n_compared, rx_n, st_n, sp_n;

    etws_bus_if bus_i ();
    etws_slave etws_slave_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .por_done_in(por_done_in), .bus(bus_i), .rx_byte_out(rx_byte_out),
        .rx_strobe_out(rx_strobe_out), .ack_req_in(ack_req_in),
        .tx_byte_in(tx_byte_in), .tx_mode_in(tx_mode_in),
        .wr_busy_in(wr_busy_in), .start_out(start_out),
        .stop_out(stop_out), .active_out(active_out));
    etws_master etws_master_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .start_in(start_in), .stop_in(stop_in), .byte_in(byte_in),
        .recover_in(recover_in), .wdata_in(wdata_in), .read_in(read_in),
        .nack_in(nack_in), .ready_out(ready_out), .rdata_out(rdata_out),
        .ack_out(ack_out), .done_out(done_out), .bus(bus_i));
    etws_sva etws_sva_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .scl(bus_i.scl), .m_sda_out(bus_i.m_sda_out),
        .m_sda_oe(bus_i.m_sda_oe), .s_sda_out(bus_i.s_sda_out),
        .s_sda_oe(bus_i.s_sda_oe), .sda(bus_i.sda));

    // ----------------------------------------
    // Clock, monitors and access tasks
    // ----------------------------------------
    initial
    begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    always @(posedge clock_in)
    begin
        if (rx_strobe_out === 1'b1)
        begin
            rx_last <= rx_byte_out;
            rx_n    <= rx_n + 1;
        end
        if (start_out === 1'b1)
            st_n <= st_n + 1;
        if (stop_out === 1'b1)
            sp_n <= sp_n + 1;
    end

    // Kind 0 Start, 1 Stop, 2 byte, 3 recovery clocking
    task automatic cmd(input int k, input logic [7:0] d,
                       input logic rd, input logic nk);
        int i;
        begin
            i = 0;
            while (ready_out !== 1'b1 && i < 9000)
            begin
                @(negedge clock_in);
                i++;
            end
            @(posedge clock_in);
            wdata_in <= d;
            read_in  <= rd;
            nack_in  <= nk;
            case (k)
                0: start_in <= 1'b1;
                1: stop_in <= 1'b1;
                2: byte_in <= 1'b1;
                default: recover_in <= 1'b1;
            endcase
            @(posedge clock_in);
            {start_in, stop_in, byte_in, recover_in} <= 4'h0;
            i = 0;
            while (done_out !== 1'b1 && i < 9000)
            begin
                @(negedge clock_in);
                i++;
            end
            `CHK(done_out, 1'b1)
        end
    endtask

    task summarize;
        begin
            $display("compared %0d mismatches %0d", n_compared, bad_count);
            if (bad_count == 0 && n_compared > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    initial
    begin
        #800000;
        bad_count++;
        summarize();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        {rst_n_in, por_done_in, ack_req_in, tx_mode_in, wr_busy_in} = 5'h0;
        {start_in, stop_in, byte_in, recover_in, read_in, nack_in} = 6'h0;
        {tx_byte_in, wdata_in, rx_last} = 24'h0;
        {bad_count, n_compared, rx_n, st_n, sp_n} = '0;
        repeat (5) @(posedge clock_in);
        rst_n_in <= 1'b1;
        // Before power-on the slave ignores the bus
        cmd(0, 8'h00, 1'b0, 1'b0);
        cmd(2, 8'hA5, 1'b0, 1'b0);
        `CHK(ack_out, 1'b0)
        `CHK(st_n, 0)
        cmd(1, 8'h00, 1'b0, 1'b0);
        @(posedge clock_in);
        por_done_in <= 1'b1;
        ack_req_in  <= 1'b1;
        // Back-to-back writes, then one refused by the memory side
        cmd(0, 8'h00, 1'b0, 1'b0);
        `CHK(st_n, 1)
        `CHK(active_out, 1'b1)
        cmd(2, 8'hA5, 1'b0, 1'b0);
        `CHK(ack_out, 1'b1)
        `CHK(rx_last, 8'hA5)
        cmd(2, 8'h3C, 1'b0, 1'b0);
        `CHK(rx_last, 8'h3C)
        `CHK(rx_n, 2)
        @(posedge clock_in);
        ack_req_in <= 1'b0;
        cmd(2, 8'h5A, 1'b0, 1'b0);
        `CHK(ack_out, 1'b0)
        `CHK(rx_last, 8'h5A)
        cmd(1, 8'h00, 1'b0, 1'b0);
        `CHK(sp_n, 1)
        `CHK(active_out, 1'b0)
        // Read two bytes, the last one not acknowledged
        @(posedge clock_in);
        ack_req_in <= 1'b1;
        tx_mode_in <= 1'b1;
        tx_byte_in <= 8'h96;
        cmd(0, 8'h00, 1'b0, 1'b0);
        cmd(2, 8'hA1, 1'b0, 1'b0);
        `CHK(ack_out, 1'b1)
        cmd(2, 8'h00, 1'b1, 1'b0);
        `CHK(rdata_out, 8'h96)
        cmd(2, 8'h00, 1'b1, 1'b1);
        `CHK(rdata_out, 8'h96)
        @(posedge clock_in);
        tx_mode_in <= 1'b0;
        cmd(1, 8'h00, 1'b0, 1'b0);
        `CHK(bus_i.sda, 1'b1)
        `CHK(bus_i.scl, 1'b1)
        // Repeated Start opens a new command
        cmd(0, 8'h00, 1'b0, 1'b0);
        cmd(2, 8'hC3, 1'b0, 1'b0);
        cmd(0, 8'h00, 1'b0, 1'b0);
        `CHK(st_n, 4)
        cmd(2, 8'h81, 1'b0, 1'b0);
        `CHK(ack_out, 1'b1)
        `CHK(rx_last, 8'h81)
        cmd(1, 8'h00, 1'b0, 1'b0);
        // Internal write cycle busy, then back to Standby
        @(posedge clock_in);
        wr_busy_in <= 1'b1;
        cmd(0, 8'h00, 1'b0, 1'b0);
        cmd(2, 8'h7E, 1'b0, 1'b0);
        `CHK(ack_out, 1'b0)
        `CHK(st_n, 4)
        cmd(1, 8'h00, 1'b0, 1'b0);
        @(posedge clock_in);
        wr_busy_in <= 1'b0;
        cmd(0, 8'h00, 1'b0, 1'b0);
        cmd(2, 8'hE7, 1'b0, 1'b0);
        `CHK(ack_out, 1'b1)
        cmd(1, 8'h00, 1'b0, 1'b0);
        // Recovery clocking finds SDA released
        cmd(3, 8'h00, 1'b0, 1'b0);
        `CHK(ack_out, 1'b1)
        // Recovery clocking frees SDA held by a cut-off read
        @(posedge clock_in);
        tx_mode_in <= 1'b1;
        tx_byte_in <= 8'h00;
        cmd(0, 8'h00, 1'b0, 1'b0);
        cmd(2, 8'hA1, 1'b0, 1'b0);
        repeat (4) @(negedge clock_in);
        `CHK(bus_i.sda, 1'b0)
        @(posedge clock_in);
        tx_mode_in <= 1'b0;
        cmd(3, 8'h00, 1'b0, 1'b0);
        `CHK(ack_out, 1'b1)
        `CHK(bus_i.sda, 1'b1)
        cmd(0, 8'h00, 1'b0, 1'b0);
        cmd(2, 8'h24, 1'b0, 1'b0);
        `CHK(ack_out, 1'b1)
        `CHK(rx_last, 8'h24)
        cmd(1, 8'h00, 1'b0, 1'b0);
        // Supply below threshold: bus ignored again
        @(posedge clock_in);
        por_done_in <= 1'b0;
        cmd(0, 8'h00, 1'b0, 1'b0);
        cmd(2, 8'h42, 1'b0, 1'b0);
        `CHK(ack_out, 1'b0)
        cmd(1, 8'h00, 1'b0, 1'b0);
        // Full power-up again after the dip
        @(posedge clock_in);
        por_done_in <= 1'b1;
        cmd(0, 8'h00, 1'b0, 1'b0);
        cmd(2, 8'h99, 1'b0, 1'b0);
        `CHK(ack_out, 1'b1)
        `CHK(rx_last, 8'h99)
        cmd(1, 8'h00, 1'b0, 1'b0);
        summarize();
    end
endmodule
